// File: ftmsf_link.sv
// Writing and reading agent that drives the two link clocks
`timescale 1ns/1ps
module ftmsf_link
    import ftmsf_pkg::*;
(
    output logic                             wclk,
    output logic                             write_en_n,
    output logic [ftmsf_pkg::DATA_W-1:0]     data_in,
    output logic                             rclk,
    output logic                             read_en_n
);
    int wcnt = 0;
    initial begin
        wclk = 0;
        rclk = 0;
        write_en_n = 1;
        read_en_n = 1;
        data_in = '0;
    end
    // One link period; both clocks stand still between calls
    task automatic cyc(input logic we, input logic re);
        write_en_n <= ~we;
        read_en_n <= ~re;
        data_in <= we ? {8'ha5, 32'h0, 32'(wcnt)} : ~data_in;
        if (we) wcnt++;
        #62.5 wclk = 1;
        rclk = 1;
        #62.5 wclk = 0;
        rclk = 0;
    endtask
    task automatic run(input int n, input logic we, input logic re);
        repeat (n) cyc(we, re);
    endtask
endmodule

// File: ftmsf_mem.sv
// Storage array with one write port and one asynchronous read port
`timescale 1ns/1ps
module ftmsf_mem #(
    parameter int AW = 14,
    parameter int DW = 72
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

// File: ftmsf_pkg.sv
// Shared constants and types for the timing-mode FIFO with status flags
package ftmsf_pkg;
    localparam int DATA_W = 72;
    localparam int ADDR_W_DEF = 14;
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h00;
    localparam logic [AXI_AW-1:0] REG_EMPTY_OFS = 8'h04;
    localparam logic [AXI_AW-1:0] REG_FULL_OFS = 8'h08;
    localparam logic [AXI_AW-1:0] REG_COUNT = 8'h0c;
    localparam int ST_MODE_BIT = 0;
    localparam int ST_EF_BIT = 1;
    localparam int ST_OR_BIT = 2;
    localparam int ST_FF_BIT = 3;
    localparam int ST_IR_BIT = 4;
    localparam int ST_PAE_BIT = 5;
    localparam int ST_PAF_BIT = 6;
    localparam int ST_HF_BIT = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int EF_STAGES = 2;
    localparam int FF_STAGES = 2;
    localparam int OR_STAGES = 3;
    localparam logic [9:0] OFS_1023 = 10'h3ff;
    localparam logic [9:0] OFS_511 = 10'h1ff;
    localparam logic [9:0] OFS_255 = 10'h0ff;
    localparam logic [9:0] OFS_127 = 10'h07f;
    localparam logic [9:0] OFS_63 = 10'h03f;
    localparam logic [9:0] OFS_31 = 10'h01f;
    localparam logic [9:0] OFS_15 = 10'h00f;
    localparam logic [9:0] OFS_7 = 10'h007;
    typedef enum logic [1:0] {
        MODE_STD  = 2'b01,
        MODE_FIRST_WORD_FALLTHROUGH_MODE = 2'b10
    } ftmsf_mode_e;
endpackage

// File: ftmsf_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module ftmsf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// File: ftmsf_top.sv
// FIFO core with standard and fall-through timing, flags and register slave
// Functional notes
// RULE1: Mode strap latched during master reset
// RULE2: Standard mode: reader requests every word
// RULE3: Fall-through: first word shows after three edges
// RULE4: Write enable low stores word each edge
// RULE5: Standard: empty flag rises after first write
// RULE6: Standard: almost-empty high at count n+1
// RULE7: Standard: half-full low above half depth
// RULE8: Standard: almost-full low at D-m words
// RULE9: Standard: full low at D, writes blocked
// RULE10: First read from full releases full indication
// RULE11: Draining raises almost-full and half-full flags
// RULE12: Standard: almost-empty low at n words
// RULE13: Standard: empty low after last read
// RULE14: Standard: empty, full flags double registered
// RULE15: Fall-through: output-ready low after first word
// RULE16: Fall-through: almost-empty high at n+2
// RULE17: Fall-through: half-full one word later
// RULE18: Fall-through: almost-full low at D+1-m
// RULE19: Fall-through: input-ready high at D+1 words
// RULE20: Fall-through: almost-empty low at n+1
// RULE21: Fall-through: output-ready high after last read
// RULE22: Output-ready three stages, input-ready two stages
// RULE23: Default offsets chosen by selects at reset
// RULE24: Programmed offsets kept within 0 to D-1
// RULE25: Simultaneous read and write keeps count
`timescale 1ns/1ps
module ftmsf_top
    import ftmsf_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          master_reset_n,
    input  wire logic                          mode_strap_serial_input,
    input  wire logic                          default_offset_sel0,
    input  wire logic                          default_offset_sel1,
    input  wire logic                          offset_load_mode,
    input  wire logic                          wclk,
    input  wire logic                          write_en_n,
    input  wire logic [ftmsf_pkg::DATA_W-1:0]  data_in,
    input  wire logic                          rclk,
    input  wire logic                          read_en_n,
    output logic      [ftmsf_pkg::DATA_W-1:0]  data_out,
    output logic                               empty_flag_n,
    output logic                               output_ready_flag_n,
    output logic                               full_flag_n,
    output logic                               input_space_flag_n,
    output logic                               almost_empty_flag_n,
    output logic                               almost_full_flag_n,
    output logic                               half_full_flag_n,
    input  wire logic [ftmsf_pkg::AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic      [1:0]                    s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ftmsf_pkg::AXI_AW-1:0]  s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic      [31:0]                   s_axi_rdata,
    output logic      [1:0]                    s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);
    import ftmsf_pkg::*;

    localparam int CNT_W = ADDR_W + 2;
    localparam int PIN_W = DATA_W + 9;
    localparam logic [CNT_W-1:0] DEPTH = CNT_W'(1 << ADDR_W);
    localparam logic [CNT_W-1:0] HALF = CNT_W'(1 << (ADDR_W - 1));

    if (ADDR_W < 11 || ADDR_W > 17) begin : g_chk
        $error("ADDR_W must lie between 11 and 17");
    end

    function automatic logic [9:0] dflt_ofs(input logic [2:0] sel);
        case (sel)
            3'h4:    dflt_ofs = OFS_1023;
            3'h2:    dflt_ofs = OFS_511;
            3'h1:    dflt_ofs = OFS_255;
            3'h0:    dflt_ofs = OFS_127;
            3'h3:    dflt_ofs = OFS_63;
            3'h6:    dflt_ofs = OFS_31;
            3'h5:    dflt_ofs = OFS_15;
            default: dflt_ofs = OFS_7;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    logic [1:0]        rst_sync_r;
    logic              rst_s;
    logic [PIN_W-1:0]  pins_s;
    logic              wclk_q_r;
    logic              rclk_q_r;
    logic              mrst_s;
    logic              wedge;
    logic              redge;
    logic              wen_s;
    logic              ren_s;
    logic [DATA_W-1:0] din_s;
    logic [DATA_W-1:0] mem_rdata;
    ftmsf_mode_e       mode_r;
    logic              first_word_fallthrough_mode;
    logic [ADDR_W-1:0] ofs_e_r;
    logic [ADDR_W-1:0] ofs_f_r;
    logic [ADDR_W-1:0] wptr_r;
    logic [ADDR_W-1:0] rptr_r;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  mem_cnt_r;
    logic              out_valid_r;
    logic [EF_STAGES-1:0]   ef_s_r;
    logic [FF_STAGES-1:0]   ff_s_r;
    logic [OR_STAGES-2:0]   or_s_r;
    logic              raw_full;
    logic              wr_do;
    logic              pop;
    logic              rd_do;
    logic              rd_take;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_s = rst_sync_r[1];

    ftmsf_sync #(.W(PIN_W)) u_sync (
        .clk   (clk),
        .rst_n (rst_s),
        .d     ({master_reset_n, mode_strap_serial_input, offset_load_mode,
                 default_offset_sel1, default_offset_sel0, rclk, read_en_n,
                 wclk, write_en_n, data_in}),
        .q     (pins_s)
    );

    assign din_s  = pins_s[DATA_W-1:0];
    assign wen_s  = ~pins_s[DATA_W];
    assign redge  = pins_s[DATA_W+3] & ~rclk_q_r;
    assign wedge  = pins_s[DATA_W+1] & ~wclk_q_r;
    assign ren_s  = ~pins_s[DATA_W+2];
    assign mrst_s = ~pins_s[DATA_W+8];
    assign first_word_fallthrough_mode   = (mode_r == MODE_FIRST_WORD_FALLTHROUGH_MODE);

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            wclk_q_r <= 1'b0;
            rclk_q_r <= 1'b0;
        end else begin
            wclk_q_r <= pins_s[DATA_W+1];
            rclk_q_r <= pins_s[DATA_W+3];
        end
    end

    // Mode latched while master reset is held
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            mode_r <= MODE_STD;
        end else if (mrst_s) begin
            mode_r <= pins_s[DATA_W+7] ? MODE_FIRST_WORD_FALLTHROUGH_MODE : MODE_STD; // [RULE1]
        end
    end

    ftmsf_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
        .clk   (clk),
        .we    (wr_do),
        .waddr (wptr_r),
        .wdata (din_s),
        .raddr (rptr_r),
        .rdata (mem_rdata)
    );

    // Write side: store on each write clock edge while enabled and not full
    assign raw_full = (cnt_r == (first_word_fallthrough_mode ? DEPTH + 1'b1 : DEPTH));
    assign wr_do = wedge & wen_s & ~raw_full & ~mrst_s; // [RULE4] [RULE9] [RULE19]

    // Read side: standard reads need enable, fall-through preloads output
    assign rd_take = first_word_fallthrough_mode & redge & out_valid_r & ren_s & ~mrst_s;
    always_comb begin
        pop = 1'b0;
        if (redge && !mrst_s && mem_cnt_r != '0) begin
            if (!first_word_fallthrough_mode) begin
                pop = ren_s & ef_s_r[EF_STAGES-1]; // [RULE2] [RULE13]
            end else begin
                pop = (!out_valid_r && or_s_r[OR_STAGES-2]) || rd_take; // [RULE3]
            end
        end
    end
    assign rd_do = first_word_fallthrough_mode ? rd_take : pop;

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            wptr_r    <= '0;
            rptr_r    <= '0;
            cnt_r     <= '0;
            mem_cnt_r <= '0;
        end else if (mrst_s) begin
            wptr_r    <= '0;
            rptr_r    <= '0;
            cnt_r     <= '0;
            mem_cnt_r <= '0;
        end else begin
            wptr_r    <= wptr_r + ADDR_W'(wr_do);
            rptr_r    <= rptr_r + ADDR_W'(pop);
            cnt_r     <= cnt_r + CNT_W'(wr_do) - CNT_W'(rd_do); // [RULE25]
            mem_cnt_r <= mem_cnt_r + CNT_W'(wr_do) - CNT_W'(pop);
        end
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            data_out    <= '0;
            out_valid_r <= 1'b0;
        end else if (mrst_s) begin
            data_out    <= '0;
            out_valid_r <= 1'b0;
        end else begin
            if (pop) begin
                data_out <= mem_rdata;
            end
            if (first_word_fallthrough_mode && pop) begin
                out_valid_r <= 1'b1;
            end else if (rd_take) begin
                out_valid_r <= 1'b0; // [RULE21]
            end
        end
    end

    // Empty in read domain: asserts at once, releases after two edges
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            ef_s_r <= '0;
            or_s_r <= '0;
        end else if (mrst_s || mem_cnt_r == '0) begin
            ef_s_r <= '0; // [RULE13]
            or_s_r <= '0;
        end else if (redge) begin
            ef_s_r <= {ef_s_r[EF_STAGES-2:0], 1'b1}; // [RULE5] [RULE14]
            or_s_r <= {or_s_r[OR_STAGES-3:0], 1'b1}; // [RULE22]
        end
    end

    // Full in write domain: asserts at once, releases after two edges
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            ff_s_r <= '1;
        end else if (mrst_s) begin
            ff_s_r <= '1;
        end else if (raw_full) begin
            ff_s_r <= '0;
        end else if (wedge) begin
            ff_s_r <= {ff_s_r[FF_STAGES-2:0], 1'b1}; // [RULE10] [RULE14] [RULE22]
        end
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            empty_flag_n        <= 1'b0;
            output_ready_flag_n <= 1'b1;
            full_flag_n         <= 1'b1;
            input_space_flag_n  <= 1'b1;
        end else begin
            empty_flag_n        <= first_word_fallthrough_mode | ef_s_r[EF_STAGES-1];
            output_ready_flag_n <= ~first_word_fallthrough_mode | ~out_valid_r; // [RULE15] [RULE21]
            full_flag_n         <= first_word_fallthrough_mode | ff_s_r[FF_STAGES-1]; // [RULE9]
            input_space_flag_n  <= ~first_word_fallthrough_mode | ~ff_s_r[FF_STAGES-1]; // [RULE19]
        end
    end

    // Programmable flags from the word count, fall-through counts one more
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            almost_empty_flag_n <= 1'b0;
            almost_full_flag_n  <= 1'b1;
            half_full_flag_n    <= 1'b1;
        end else if (first_word_fallthrough_mode) begin
            almost_empty_flag_n <= cnt_r > CNT_W'(ofs_e_r) + 1'b1; // [RULE16] [RULE20]
            almost_full_flag_n  <= cnt_r < DEPTH + 1'b1 - CNT_W'(ofs_f_r); // [RULE18] [RULE11]
            half_full_flag_n    <= cnt_r <= HALF + 1'b1; // [RULE17] [RULE11]
        end else begin
            almost_empty_flag_n <= cnt_r > CNT_W'(ofs_e_r); // [RULE6] [RULE12]
            almost_full_flag_n  <= cnt_r < DEPTH - CNT_W'(ofs_f_r); // [RULE8] [RULE11]
            half_full_flag_n    <= cnt_r <= HALF; // [RULE7] [RULE11]
        end
    end

    // Register slave
    logic              aw_got_r;
    logic              w_got_r;
    logic [AXI_AW-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              wr_commit;
    logic [31:0]       status_w;

    assign wr_commit = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign status_w = {24'h0, ~half_full_flag_n, ~almost_full_flag_n, ~almost_empty_flag_n,
                       ~input_space_flag_n, full_flag_n, output_ready_flag_n, empty_flag_n,
                       first_word_fallthrough_mode};

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_commit) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r == REG_STATUS || awaddr_r == REG_EMPTY_OFS ||
                                 awaddr_r == REG_FULL_OFS || awaddr_r == REG_COUNT)
                                ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_r      <= 1'b0;
                w_got_r       <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Offsets: defaults at master reset, software may reprogram afterwards
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            ofs_e_r <= ADDR_W'(OFS_127);
            ofs_f_r <= ADDR_W'(OFS_127);
        end else if (mrst_s) begin
            ofs_e_r <= ADDR_W'(dflt_ofs(pins_s[DATA_W+6:DATA_W+4])); // [RULE23]
            ofs_f_r <= ADDR_W'(dflt_ofs(pins_s[DATA_W+6:DATA_W+4])); // [RULE23]
        end else if (wr_commit && awaddr_r == REG_EMPTY_OFS) begin
            ofs_e_r <= ADDR_W'(merge(32'(ofs_e_r), wdata_r, wstrb_r)); // [RULE24]
        end else if (wr_commit && awaddr_r == REG_FULL_OFS) begin
            ofs_f_r <= ADDR_W'(merge(32'(ofs_f_r), wdata_r, wstrb_r)); // [RULE24]
        end
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
                REG_STATUS:    s_axi_rdata <= status_w;
                REG_EMPTY_OFS: s_axi_rdata <= 32'(ofs_e_r);
                REG_FULL_OFS:  s_axi_rdata <= 32'(ofs_f_r);
                REG_COUNT:     s_axi_rdata <= 32'(cnt_r);
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_s);

    chk_no_full_write: assert property ( // [RULE9] [RULE19]
        wr_do |-> cnt_r < (first_word_fallthrough_mode ? DEPTH + 1'b1 : DEPTH))
        else $error("write taken while full");
    chk_empty_read_ignored: assert property ( // [RULE13] [RULE21]
        pop |-> mem_cnt_r != '0 && (first_word_fallthrough_mode || empty_flag_n))
        else $error("word popped from empty store");
    chk_count_balance: assert property (!$past(mrst_s) && !mrst_s |-> // [RULE25]
        cnt_r == $past(cnt_r) + CNT_W'($past(wr_do)) - CNT_W'($past(rd_do)))
        else $error("word count drifted");
    chk_ef_rise_cause: assert property (!first_word_fallthrough_mode && $rose(empty_flag_n) |-> // [RULE5] [RULE14]
        $past(mem_cnt_r) != '0 && $past(ef_s_r[0], 2))
        else $error("empty flag released early");
    chk_pae_std: assert property (!first_word_fallthrough_mode && !mrst_s && cnt_r <= CNT_W'(ofs_e_r) ##1 // [RULE12]
        $stable(cnt_r) |-> !almost_empty_flag_n)
        else $error("almost-empty not low at offset");
    chk_full_std: assert property ( // [RULE9]
        !first_word_fallthrough_mode && !mrst_s && cnt_r == DEPTH |-> ##2 !full_flag_n)
        else $error("full flag not low at depth");
    chk_or_three_edges: assert property ($fell(output_ready_flag_n) |-> // [RULE3] [RULE22]
        $past(or_s_r[OR_STAGES-2], 2))
        else $error("output ready fell without staged data");
    chk_ir_depth: assert property ( // [RULE19]
        first_word_fallthrough_mode && !mrst_s && cnt_r == DEPTH + 1'b1 |-> ##2 input_space_flag_n)
        else $error("input ready not high at depth plus one");
    chk_hf_first_word_fallthrough_mode: assert property (first_word_fallthrough_mode && cnt_r == HALF + 2'd2 ##1 $stable(cnt_r) // [RULE17]
        |-> !half_full_flag_n)
        else $error("half-full late in fall-through");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");

    cov_first_word_fallthrough_mode_first: cover property ($fell(output_ready_flag_n));
    cov_std_full: cover property ($fell(full_flag_n));
    cov_reg_write: cover property (wr_commit && awaddr_r == REG_EMPTY_OFS);
    cov_rd_wr_same: cover property (wr_do && rd_do);
endmodule

// File: tb_fifo_timing_mode_status_flags.sv
// Self-checking bench for the timing-mode FIFO
`timescale 1ns/1ps
module tb_fifo_timing_mode_status_flags;
    import ftmsf_pkg::*;
    logic              clk = 0, rst_n = 0, master_reset_n = 0, mode_strap_serial_input = 0;
    logic              default_offset_sel0 = 1, default_offset_sel1 = 1, offset_load_mode = 1;
    logic              wclk, write_en_n, rclk, read_en_n;
    logic [DATA_W-1:0] data_in, data_out;
    logic              empty_flag_n, output_ready_flag_n, full_flag_n, input_space_flag_n;
    logic              almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
    logic [AXI_AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0]       s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
    logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic              s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int                error_cnt = 0, check_count = 0;

    ftmsf_top #(.ADDR_W(11)) dut (.*);
    ftmsf_link lnk (.*);

    initial forever #5 clk = ~clk;

    function automatic logic [DATA_W-1:0] w(input int i);
        return {8'ha5, 32'h0, 32'(i)};
    endfunction
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic lk(input int n, input logic we, input logic re);
        lnk.run(n, we, re);
        lnk.run(3, 0, 0);
        repeat (10) @(posedge clk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1 && t < 50);
        s_axi_bready <= 0;
        @(posedge clk);
        chk(t < 50 && s_axi_bresp === RESP_OKAY, "write response");
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk);
            t++;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1 && t < 50);
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge clk);
        chk(t < 50, "read timeout");
    endtask
    task automatic cnt_is(input int c);
        axi_rd(REG_COUNT);
        chk(rd === 32'(c), "word count");
    endtask
    task automatic mreset(input logic fw);
        master_reset_n <= 0;
        mode_strap_serial_input <= fw;
        repeat (8) @(posedge clk);
        master_reset_n <= 1;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_std;
        mreset(0);
        chk(empty_flag_n === 0 && almost_empty_flag_n === 0, "std idle");
        chk(output_ready_flag_n === 1, "ready unused");
        axi_wr(REG_EMPTY_OFS, 32'h7);
        axi_rd(REG_EMPTY_OFS);
        chk(rd === 32'h7, "offset readback");
        axi_rd(8'h40);
        chk(rs === RESP_SLVERR && rd === 32'h0, "unmapped");
        lk(1, 1, 0);
        chk(empty_flag_n === 1 && data_out === '0, "first write");
        lk(7, 1, 0);
        chk(almost_empty_flag_n === 1, "ae at n+1");
        lk(1, 1, 1);
        cnt_is(8);
        lk(1, 0, 1);
        chk(almost_empty_flag_n === 0 && data_out === w(1), "ae at n");
        lk(9, 0, 1);
        chk(empty_flag_n === 0, "empty again");
        lk(1, 1, 0);
        lk(1, 0, 1);
        chk(data_out === w(9), "read while empty");
        $display("standard mode test done");
    endtask
    task automatic t_full;
        lk(2049, 1, 0);
        chk(full_flag_n === 0 && half_full_flag_n === 0, "full");
        cnt_is(2048);
        lk(1, 0, 1);
        chk(full_flag_n === 1, "full released");
        lk(6, 0, 1);
        chk(almost_full_flag_n === 0, "af at D-m");
        lk(1, 0, 1);
        chk(almost_full_flag_n === 1 && half_full_flag_n === 0, "af off");
        $display("full test done");
    endtask
    task automatic t_first_word_fallthrough_mode;
        int b;
        default_offset_sel0 <= 0;
        mreset(1);
        b = lnk.wcnt;
        chk(output_ready_flag_n === 1 && input_space_flag_n === 0, "first_word_fallthrough_mode idle");
        axi_rd(REG_FULL_OFS);
        chk(rd === 32'h1f, "default offset");
        axi_wr(REG_EMPTY_OFS, 32'h7);
        lk(1, 1, 0);
        chk(output_ready_flag_n === 0 && data_out === w(b), "fall through");
        lk(8, 1, 0);
        chk(almost_empty_flag_n === 1, "ae at n+2");
        lk(1, 0, 1);
        chk(almost_empty_flag_n === 0 && data_out === w(b + 1), "ae at n+1");
        lk(8, 0, 1);
        chk(output_ready_flag_n === 1, "drained");
        lk(2050, 1, 0);
        chk(input_space_flag_n === 1 && half_full_flag_n === 0, "input full");
        cnt_is(2049);
        lk(1, 0, 1);
        chk(input_space_flag_n === 0, "input space back");
        $display("fall-through test done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        repeat (4) @(posedge clk);
        t_std;
        t_full;
        t_first_word_fallthrough_mode;
        tally_and_finish;
    end
    initial begin
        #800000;
        error_cnt++;
        tally_and_finish;
    end
endmodule
